// File: hdl/flash_bus_host.sv
`timescale 1ns/1ns
`include "flash_bus_regs.svh"
module flash_bus_host (
	input  wire logic                      clock_i,          // 50 MHz clock
	input  wire logic                      rst_n_i,          // Async reset, low
	input  wire logic                      req_valid_i,      // Request strobe
	input  wire flash_bus_pkg::host_op_t   req_op_i,         // Request kind
	input  wire logic [23:0]               req_addr_i,       // Byte or word address
	input  wire logic [15:0]               req_wdata_i,      // Write data
	input  wire logic                      byte_mode_i,      // 1: byte-wide bus
	input  wire logic                      prog_enable_i,    // 1: allow alteration
	output logic                           req_ready_o,      // Idle, accepts request
	output logic                           rsp_valid_o,      // Read data valid pulse
	output logic [15:0]                    rsp_rdata_o,      // Read data
	output logic                           flash_busy_o,     // Synced status pin low
	output logic                           chip_select_0_o,  // Select 0, active low
	output logic                           chip_select_1_o,  // Select 1, active low
	output logic                           chip_select_2_o,  // Select 2, held low
	output logic                           output_enable_n_o, // Output enable
	output logic                           write_enable_n_o, // Write enable
	output logic                           reset_powerdown_n_o, // Reset/power-down
	output logic                           byte_width_n_o,   // Low: byte mode
	output logic                           program_voltage_enable_o, // Program enable
	output logic [23:0]                    addr_o,           // Address lines
	output logic [15:0]                    data_o,           // Data out
	output logic                           data_oe_o,        // High: host drives data
	input  wire logic [15:0]               data_i,           // Data in
	input  wire logic                      ready_busy_out_i  // Status pin level
);
	import flash_bus_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Timing counts
	localparam logic [15:0] CNT_RESET  = 16'(`CYC_RESET);
	localparam logic [15:0] CNT_WAKE_R = 16'(`CYC_WAKE_RD);
	localparam logic [15:0] CNT_WAKE_W = 16'(`CYC_WAKE_WR);
	localparam logic [15:0] CNT_SETUP  = 16'(`CYC_SETUP);
	localparam logic [15:0] CNT_STROBE = 16'(`CYC_STROBE);
	localparam logic [15:0] CNT_HOLD   = 16'(`CYC_HOLD);

	// Whole module state in one record
	typedef struct packed {
		host_state_t state;        // Sequencer state
		host_op_t    op;           // Op in flight
		logic [15:0] cnt;          // Phase countdown
		logic [15:0] wr_gap;       // Cycles left before a write is legal
		logic        byte_mode;    // Latched width
		logic        sync1;        // Status pin sync stage one
		logic        sync2;        // Status pin sync stage two
		logic [15:0] dsync1;       // Data sync stage one
		logic [15:0] dsync2;       // Data sync stage two
		logic        ready;        // Accept flag
		logic        rsp_valid;    // Read done pulse
		logic [15:0] rdata;        // Read data
		logic        cs_on;        // Select asserted
		logic        oe_n;         // Output enable pin
		logic        we_n;         // Write enable pin
		logic        rp_n;         // Reset pin
		logic        byte_n;       // Width pin
		logic        program_voltage_enable;         // Program enable pin
		logic [23:0] addr;         // Address pin
		logic [15:0] wdata;        // Data out
		logic        doe;          // Data drive enable
	} host_reg_t;

	host_reg_t st_reg;   // Registered state
	host_reg_t st_next;  // Next state

	////////////////////////////////////////////////////////////////////////////
	// Byte-mode read data sits in the low lane
	function automatic logic [15:0] lane_data(input logic bm, input logic [15:0] d);
		lane_data = bm ? {8'h00, d[7:0]} : d;
	endfunction : lane_data

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		st_next           = st_reg;
		st_next.rsp_valid = 1'b0;
		// Status pin and data pass two flops before use
		st_next.sync1     = ready_busy_out_i;
		st_next.sync2     = st_reg.sync1;
		st_next.dsync1    = data_i;
		st_next.dsync2    = st_reg.dsync1;
		st_next.program_voltage_enable      = prog_enable_i;
		if (st_reg.wr_gap != 16'h0000) begin
			st_next.wr_gap = st_reg.wr_gap - 16'h0001;
		end
		unique case (st_reg.state)
			// Hold reset low the full pulse time
			ST_RESET: begin
				st_next.rp_n  = 1'b0;
				st_next.cs_on = 1'b0;
				st_next.oe_n  = 1'b1;
				st_next.we_n  = 1'b1;
				st_next.doe   = 1'b0;
				st_next.ready = 1'b0;
				if (st_reg.cnt <= 16'h0001) begin
					st_next.rp_n   = 1'b1;
					st_next.state  = ST_WAKE;
					st_next.cnt    = CNT_WAKE_R;
					st_next.wr_gap = CNT_WAKE_W;
				end else begin
					st_next.cnt = st_reg.cnt - 16'h0001;
				end
			end
			// Wake-up wait before any read
			ST_WAKE: begin
				if (st_reg.cnt <= 16'h0001) begin
					st_next.state = ST_IDLE;
					st_next.ready = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt - 16'h0001;
				end
			end
			// Wait for a request
			ST_IDLE: begin
				if (req_valid_i) begin
					st_next.ready = 1'b0;
					st_next.op    = req_op_i;
					if (req_op_i == OP_RESET) begin
						// Reset may abort running work; device copes
						st_next.state = ST_RESET;
						st_next.cnt   = CNT_RESET;
						st_next.rp_n  = 1'b0;
					end else begin
						st_next.byte_mode = byte_mode_i;
						st_next.byte_n    = ~byte_mode_i;
						// Byte mode passes the lane bit; word mode ignores it
						st_next.addr  = byte_mode_i ? req_addr_i
							: {req_addr_i[23:1], 1'b0};
						st_next.wdata = req_wdata_i;
						st_next.doe   = (req_op_i == OP_WRITE);
						st_next.cs_on = 1'b1;
						st_next.state = ST_SETUP;
						st_next.cnt   = CNT_SETUP;
					end
				end
			end
			// Address setup, then strobe
			ST_SETUP: begin
				if (st_reg.cnt <= 16'h0001 &&
				    (st_reg.op == OP_READ || st_reg.wr_gap == 16'h0000)) begin
					st_next.state = ST_STROBE;
					st_next.cnt   = CNT_STROBE;
					// Only one enable ever goes low
					if (st_reg.op == OP_READ) begin
						st_next.oe_n = 1'b0;
					end else begin
						st_next.we_n = 1'b0;
					end
				end else if (st_reg.cnt > 16'h0001) begin
					st_next.cnt = st_reg.cnt - 16'h0001;
				end
			end
			// Strobe width; read samples synced data at the end
			ST_STROBE: begin
				if (st_reg.cnt <= 16'h0001) begin
					if (st_reg.op == OP_READ) begin
						st_next.rdata     = lane_data(st_reg.byte_mode, st_reg.dsync2);
						st_next.rsp_valid = 1'b1;
					end
					// Write enable rises first so it ends the write
					st_next.oe_n  = 1'b1;
					st_next.we_n  = 1'b1;
					st_next.state = ST_HOLD;
					st_next.cnt   = CNT_HOLD;
				end else begin
					st_next.cnt = st_reg.cnt - 16'h0001;
				end
			end
			// Hold, then deselect; deselect does not stop device work
			ST_HOLD: begin
				if (st_reg.cnt <= 16'h0001) begin
					st_next.cs_on = 1'b0;
					st_next.doe   = 1'b0;
					st_next.state = ST_IDLE;
					st_next.ready = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt - 16'h0001;
				end
			end
			// Unused codes fall back to a fresh reset pulse, the only safe restart
			default: begin
				st_next.state = ST_RESET;
				st_next.cnt   = CNT_RESET;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; reset starts a reset pulse on the flash
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg        <= '0;
			st_reg.state  <= ST_RESET;
			st_reg.op     <= OP_READ;
			st_reg.cnt    <= CNT_RESET;
			st_reg.oe_n   <= 1'b1;
			st_reg.we_n   <= 1'b1;
			st_reg.byte_n <= 1'b1;
			st_reg.sync1  <= 1'b1;
			st_reg.sync2  <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flops except cs2, tied low; select uses cs0 low, cs1 low, cs2 low
	assign req_ready_o              = st_reg.ready;
	assign rsp_valid_o              = st_reg.rsp_valid;
	assign rsp_rdata_o              = st_reg.rdata;
	assign flash_busy_o             = ~st_reg.sync2;
	assign chip_select_0_o          = ~st_reg.cs_on;
	assign chip_select_1_o          = ~st_reg.cs_on;
	assign chip_select_2_o          = 1'b0;
	assign output_enable_n_o        = st_reg.oe_n;
	assign write_enable_n_o         = st_reg.we_n;
	assign reset_powerdown_n_o      = st_reg.rp_n;
	assign byte_width_n_o           = st_reg.byte_n;
	assign program_voltage_enable_o = st_reg.program_voltage_enable;
	assign addr_o                   = st_reg.addr;
	assign data_o                   = st_reg.wdata;
	assign data_oe_o                = st_reg.doe;

endmodule : flash_bus_host

// File: hdl/flash_bus_pkg.sv
package flash_bus_pkg;

	// Host sequencer states
	typedef enum logic [2:0] {
		ST_RESET,
		ST_WAKE,
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD
	} host_state_t;

	// Kind of bus cycle requested by the user
	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_RESET
	} host_op_t;

endpackage : flash_bus_pkg

// File: hdl/flash_bus_regs.svh
`ifndef FLASH_BUS_REGS_SVH
`define FLASH_BUS_REGS_SVH

// Clock period in ns
`define CLK_PERIOD_NS       20
// Minimum reset pulse width in ns (plain default)
`define T_RESET_PULSE_NS    25000
// Wake-up time after reset release before reads in ns (plain default)
`define T_WAKE_READ_NS      150
// Recovery time after reset release before writes in ns (plain default)
`define T_WAKE_WRITE_NS     1000
// Address/data setup before strobe in ns (plain default)
`define T_SETUP_NS          60
// Strobe low width in ns (plain default)
`define T_STROBE_NS         120
// Hold after strobe release in ns (plain default)
`define T_HOLD_NS           40
// Cycle counts, least times rounded up
`define CYC_RESET   ((`T_RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_WAKE_RD ((`T_WAKE_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_WAKE_WR ((`T_WAKE_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SETUP   ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_STROBE  ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_HOLD    ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Status value of a ready device
`define STATUS_READY        8'h80
// Position of the ready bit in status
`define STATUS_READY_BIT    7

`endif

// File: tb/flash_bus_host_checker.sv
`timescale 1ns/1ns
`include "flash_bus_regs.svh"
module flash_bus_host_checker (
	input wire logic        clock_i,             // Clock
	input wire logic        rst_n_i,             // Reset
	input wire logic        req_ready_o,         // Idle
	input wire logic        rsp_valid_o,         // Read pulse
	input wire logic        chip_select_0_o,     // Select 0
	input wire logic        chip_select_1_o,     // Select 1
	input wire logic        chip_select_2_o,     // Select 2
	input wire logic        output_enable_n_o,   // Output enable
	input wire logic        write_enable_n_o,    // Write enable
	input wire logic        reset_powerdown_n_o, // Flash reset
	input wire logic        byte_width_n_o,      // Byte mode low
	input wire logic [23:0] addr_o,              // Address
	input wire logic [15:0] data_o,              // Host data
	input wire logic        data_oe_o            // Host drives data
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	int low_cnt; // Cycles with flash reset low
	////////////////////////////////////////////////////////////////
	// Pulse width counter, cleared whenever the flash leaves reset
	always_ff @(posedge clock_i or negedge rst_n_i)
		if (!rst_n_i) low_cnt <= 0;
		else low_cnt <= reset_powerdown_n_o ? 0 : low_cnt + 1;
	int up_cnt; // Cycles since the flash left reset
	////////////////////////////////////////////////////////////////
	// Wake-up counter, cleared while the flash is held in reset
	always_ff @(posedge clock_i or negedge rst_n_i)
		if (!rst_n_i) up_cnt <= 0;
		else up_cnt <= reset_powerdown_n_o ? up_cnt + 1 : 0;
	a_rd_wake: assert property (!output_enable_n_o |-> up_cnt >= `CYC_WAKE_RD)
		else $error("read before wake-up time");
	a_wr_recover: assert property (!write_enable_n_o |-> up_cnt >= `CYC_WAKE_WR)
		else $error("write before recovery time");
	a_strobe_excl: assert property (!(!output_enable_n_o && !write_enable_n_o))
		else $error("output and write enable low together");
	a_read_sel: assert property (!output_enable_n_o |-> !chip_select_0_o && !chip_select_1_o
		&& !chip_select_2_o) else $error("read while not selected");
	a_read_pins: assert property (!output_enable_n_o |-> write_enable_n_o
		&& reset_powerdown_n_o && !data_oe_o) else $error("read pin levels wrong");
	a_write_drive: assert property (!write_enable_n_o |-> data_oe_o && !chip_select_0_o)
		else $error("write without data or select");
	a_we_latch: assert property ($rose(write_enable_n_o) |-> !chip_select_0_o && data_oe_o
		&& $stable(addr_o) && $stable(data_o)) else $error("write latch edge unstable");
	a_read_pulse: assert property ($rose(output_enable_n_o) |-> rsp_valid_o)
		else $error("read strobe end without data pulse");
	a_idle_standby: assert property (req_ready_o |-> chip_select_0_o && chip_select_1_o
		&& output_enable_n_o && write_enable_n_o) else $error("idle but selected");
	a_word_lane: assert property (!chip_select_0_o && byte_width_n_o |-> addr_o[0] == 1'b0)
		else $error("word mode lowest address set");
	a_rst_quiet: assert property (!reset_powerdown_n_o |-> output_enable_n_o
		&& write_enable_n_o && !req_ready_o) else $error("bus activity in flash reset");
	a_rst_width: assert property ($rose(reset_powerdown_n_o) |-> low_cnt >= `CYC_RESET - 1)
		else $error("flash reset pulse too short");
endmodule : flash_bus_host_checker
bind flash_bus_host flash_bus_host_checker flash_bus_host_checker_inst (.clock_i, .rst_n_i,
	.req_ready_o, .rsp_valid_o, .chip_select_0_o, .chip_select_1_o, .chip_select_2_o,
	.output_enable_n_o, .write_enable_n_o, .reset_powerdown_n_o, .byte_width_n_o, .addr_o,
	.data_o, .data_oe_o);

// File: tb/flash_bus_operation_control_test.sv
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module flash_bus_operation_control_test;
	import flash_bus_pkg::*;
	logic        clock_i = 0, rst_n_i = 0, req_valid_i = 0, byte_mode_i = 0, prog_enable_i = 1;
	host_op_t    req_op_i = OP_READ;
	logic [23:0] req_addr_i = 24'h0, addr_o;
	logic [15:0] req_wdata_i = 16'h0, rsp_rdata_o, data_o, data_i, dev_data, rd;
	logic        req_ready_o, rsp_valid_o, flash_busy_o, chip_select_0_o, chip_select_1_o;
	logic        chip_select_2_o, output_enable_n_o, write_enable_n_o, reset_powerdown_n_o;
	logic        byte_width_n_o, program_voltage_enable_o, data_oe_o, ready_busy_out_i;
	int          n_mismatch = 0, comparisons = 0, cycles = 0;
	assign data_i = data_oe_o ? data_o : dev_data; // Bus level from both drivers
	flash_bus_host flash_bus_host_inst (.clock_i, .rst_n_i, .req_valid_i, .req_op_i,
		.req_addr_i, .req_wdata_i, .byte_mode_i, .prog_enable_i, .req_ready_o, .rsp_valid_o,
		.rsp_rdata_o, .flash_busy_o, .chip_select_0_o, .chip_select_1_o, .chip_select_2_o,
		.output_enable_n_o, .write_enable_n_o, .reset_powerdown_n_o, .byte_width_n_o,
		.program_voltage_enable_o, .addr_o, .data_o, .data_oe_o, .data_i, .ready_busy_out_i);
	flash_dev_model flash_dev_model_inst (.cs0_i(chip_select_0_o), .cs1_i(chip_select_1_o),
		.cs2_i(chip_select_2_o), .oe_n_i(output_enable_n_o), .we_n_i(write_enable_n_o),
		.rp_n_i(reset_powerdown_n_o), .bw_n_i(byte_width_n_o), .addr_i(addr_o),
		.program_voltage_enable_i(program_voltage_enable_o), .data_i(data_o), .data_o(dev_data),
		.ready_busy_out_o(ready_busy_out_i));
	initial forever #10 clock_i = ~clock_i;
	task automatic summarize;
		if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	always @(posedge clock_i) begin // Hang guard, whole run is near 3000 cycles
		cycles++;
		if (cycles == 10000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic step;
		@(posedge clock_i);
		#1;
	endtask : step
	// One bus cycle: wait idle, present for one edge, collect the data pulse
	task automatic op(input host_op_t o, input logic [23:0] a, input logic [15:0] d);
		while (req_ready_o !== 1'b1) step();
		req_op_i = o;
		req_addr_i = a;
		req_wdata_i = d;
		req_valid_i = 1;
		step();
		req_valid_i = 0;
		while (req_ready_o !== 1'b1) begin
			if (rsp_valid_o === 1'b1) rd = rsp_rdata_o;
			step();
		end
	endtask : op
	task automatic wait_idle;
		while (flash_busy_o !== 1'b0) step();
	endtask : wait_idle
	task automatic t_word;
		op(OP_WRITE, 24'h4, 16'h0040);
		op(OP_WRITE, 24'h4, 16'h1234);
		op(OP_READ, 24'h0, 16'h0);
		`CHK(rd[7], 1'b0)
		`CHK(flash_busy_o, 1'b1)
		wait_idle();
		op(OP_READ, 24'h0, 16'h0);
		`CHK(rd[7:0], 8'h80)
		op(OP_WRITE, 24'h77, 16'h00ff);
		op(OP_READ, 24'h4, 16'h0);
		`CHK(rd, 16'h1234)
	endtask : t_word
	task automatic t_byte;
		byte_mode_i = 1;
		op(OP_WRITE, 24'h9, 16'h0040);
		op(OP_WRITE, 24'h5, 16'h0056);
		wait_idle();
		op(OP_WRITE, 24'h0, 16'h00ff);
		op(OP_READ, 24'h4, 16'h0);
		`CHK(rd, 16'h0034)
		op(OP_READ, 24'h5, 16'h0);
		`CHK(rd, 16'h0056)
		byte_mode_i = 0;
		op(OP_READ, 24'h5, 16'h0);
		`CHK(rd, 16'h5634)
	endtask : t_byte
	task automatic t_lock;
		prog_enable_i = 0;
		op(OP_WRITE, 24'h8, 16'h0040);
		op(OP_WRITE, 24'h8, 16'h0000);
		`CHK(program_voltage_enable_o, 1'b0)
		op(OP_WRITE, 24'h8, 16'h00ff);
		op(OP_READ, 24'h8, 16'h0);
		`CHK(rd, 16'hffff)
		prog_enable_i = 1;
	endtask : t_lock
	task automatic t_reset;
		op(OP_WRITE, 24'ha, 16'h0040);
		op(OP_WRITE, 24'ha, 16'h0000);
		op(OP_RESET, 24'h0, 16'h0);
		`CHK(flash_busy_o, 1'b0)
		op(OP_READ, 24'h5, 16'h0);
		`CHK(rd, 16'h5634)
		op(OP_WRITE, 24'h3, 16'h0070);
		op(OP_READ, 24'h3, 16'h0);
		`CHK(rd[7:0], 8'h80)
	endtask : t_reset
	initial begin
		repeat (12) @(posedge clock_i);
		#1;
		rst_n_i = 1;
		t_word();
		t_byte();
		t_lock();
		t_reset();
		summarize();
	end
endmodule : flash_bus_operation_control_test

// File: tb/flash_dev_model.sv
`timescale 1ns/1ns
module flash_dev_model #(
	parameter int BUSY_CYC = 100 // Algorithm time in 20 ns steps, plain default
) (
	input  wire logic        cs0_i, // Select 0
	input  wire logic        cs1_i, // Select 1
	input  wire logic        cs2_i, // Select 2
	input  wire logic        oe_n_i, // Output enable
	input  wire logic        we_n_i, // Write enable
	input  wire logic        rp_n_i, // Reset/power-down
	input  wire logic        bw_n_i, // Low: byte mode
	input  wire logic        program_voltage_enable_i, // Program enable
	input  wire logic [23:0] addr_i, // Address
	input  wire logic [15:0] data_i, // Host data
	output logic      [15:0] data_o, // Device data
	output logic             ready_busy_out_o // Status pin, pulled up
);
	logic [15:0] mem [256]; // Small array window
	logic [15:0] pat = 16'h5a5a, mask, val, word; // Pattern stands in for float
	logic sel, armed = 0, st_mode = 0, prog_next = 0, abort_hold = 0;
	int busy = 0; // Steps left of the algorithm
	initial foreach (mem[i]) mem[i] = 16'hffff;
	assign sel = rp_n_i && ((!cs2_i && !cs1_i && !cs0_i) || (cs2_i && !(cs1_i && cs0_i)));
	assign ready_busy_out_o = !(busy > 0 || abort_hold);
	always #20 begin // Runs on whether selected or not
		pat = ~pat;
		if (busy > 0) busy = busy - 1;
	end
	always @(negedge we_n_i) armed = sel;
	////////////////////////////////////////////////////////////////
	// Command latch on whichever ends the write first
	always @(posedge we_n_i or negedge sel) begin
		if (armed) begin
			armed = 0;
			if (prog_next) begin
				prog_next = 0;
				st_mode = 1;
				if (program_voltage_enable_i) begin
					if (bw_n_i) mem[addr_i[8:1]] = data_i;
					else if (addr_i[0]) mem[addr_i[8:1]][15:8] = data_i[7:0];
					else mem[addr_i[8:1]][7:0] = data_i[7:0];
					busy = BUSY_CYC;
				end
			end else if (data_i[7:0] == 8'h40) prog_next = 1;
			else if (data_i[7:0] == 8'h70) st_mode = 1;
			else if (data_i[7:0] == 8'hff) st_mode = 0;
		end
	end
	always @(negedge rp_n_i) begin
		abort_hold = busy > 0;
		busy = 0;
		prog_next = 0;
	end
	always @(posedge rp_n_i) begin
		abort_hold = 0;
		st_mode = 0;
	end
	always_comb begin
		word = mem[addr_i[8:1]];
		mask = 16'h0000;
		val = word;
		if (sel && !oe_n_i) begin
			if (st_mode) begin
				val = {8'h00, busy == 0, 7'h00};
				mask = busy > 0 ? 16'h0080 : 16'h00ff;
			end else if (!bw_n_i) begin
				val = {8'h00, addr_i[0] ? word[15:8] : word[7:0]};
				mask = 16'h00ff;
			end else mask = 16'hffff;
		end
		data_o = (val & mask) | (pat & ~mask);
	end
endmodule : flash_dev_model
